// ---- hw/wit_watch_timer.v ----
// watch timer with shared prescaler, 5-bit watch counter and interval timer
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "wit_consts.vh"
module wit_watch_timer #(
  parameter ADDR_WIDTH = 16
) (
  // clock and reset
  input  wire                  clk,
  input  wire                  reset_n,
  // subsystem clock pin, sampled
  input  wire                  sub_clock_pin,
  // register port
  input  wire [ADDR_WIDTH-1:0] reg_addr,
  input  wire [7:0]            reg_wdata,
  input  wire [7:0]            reg_wmask,
  input  wire                  reg_write,
  input  wire                  reg_read,
  output reg  [7:0]            reg_rdata,
  // events
  output reg                   watch_period_flag,
  output reg                   interval_irq,
  output reg                   standby_release,
  output reg                   irq
);

  // register bank
  reg [7:0]                      clock_select_reg;
  reg [7:0]                      watch_mode_reg;
  reg [1:0]                      irq_status;
  reg [1:0]                      irq_mask;
  // synchroniser for the subsystem clock pin
  reg                            sub_sync1;
  reg                            sub_sync2;
  reg                            sub_prev;
  // counters
  reg [`WIT_MAIN_DIV_LOG2-1:0]   main_div;
  reg [`WIT_PRESCALER_WIDTH-1:0] prescaler;
  reg [`WIT_COUNTER_WIDTH-1:0]   watch_counter;
  // next values
  reg [7:0]                      next_clock_select;
  reg [7:0]                      next_watch_mode;
  reg [1:0]                      next_irq_mask;
  reg [1:0]                      next_irq_status;
  reg [`WIT_MAIN_DIV_LOG2-1:0]   next_main_div;
  reg [`WIT_PRESCALER_WIDTH-1:0] next_prescaler;
  reg [`WIT_COUNTER_WIDTH-1:0]   next_watch_counter;
  reg [7:0]                      next_rdata;
  reg                            next_irq;
  // event decode
  reg                            interval_end;
  reg                            watch_set;
  reg [1:0]                      status_event;
  reg [1:0]                      status_clear;

  // address decode
  wire hit_clock_select   = reg_addr == `WIT_ADDR_CLOCK_SELECT;
  wire hit_mode           = reg_addr == `WIT_ADDR_MODE;
  wire hit_status         = reg_addr == `WIT_ADDR_IRQ_STATUS;
  wire hit_mask           = reg_addr == `WIT_ADDR_IRQ_MASK;
  wire write_clock_select = reg_write && hit_clock_select;
  wire write_mode         = reg_write && hit_mode;
  wire write_status       = reg_write && hit_status;
  wire write_mask         = reg_write && hit_mask;

  // control fields
  wire       watch_clock_source_sel = clock_select_reg[`WIT_BIT_SOURCE_SEL];
  wire       prescaler_run          = watch_mode_reg[`WIT_BIT_PRESCALER_RUN];
  wire       watch_counter_run      = watch_mode_reg[`WIT_BIT_COUNTER_RUN];
  wire       flag_period_sel_low    = watch_mode_reg[`WIT_BIT_FLAG_SEL_LOW];
  wire       flag_period_sel_high   = watch_mode_reg[`WIT_BIT_FLAG_SEL_HIGH];
  wire [1:0] flag_period_sel        = {flag_period_sel_high, flag_period_sel_low};
  wire [2:0] interval_sel           = watch_mode_reg[`WIT_FIELD_INTERVAL_LSB +: 3];

  // one watch clock tick: main over 2^8, or a rising subsystem edge
  wire                           main_tick      = &main_div;
  wire                           sub_tick       = sub_sync2 & ~sub_prev;
  wire                           watch_tick     = watch_clock_source_sel ? sub_tick : main_tick;
  wire                           prescaler_step = prescaler_run && watch_tick;
  wire                           prescaler_wrap = prescaler_step && (&prescaler);
  wire [`WIT_PRESCALER_WIDTH-1:0] prescaler_inc  = prescaler + 1'b1;
  wire [`WIT_PRESCALER_WIDTH-1:0] prescaler_fall = prescaler & ~prescaler_inc;

  // watch flag candidates: full counter 2^14, low four counter bits 2^13
  wire flag_at_long  = prescaler_wrap && watch_counter_run && (&watch_counter);
  wire flag_at_half  = prescaler_wrap && watch_counter_run && (&watch_counter[3:0]);
  wire flag_at_32    = prescaler_step && (&prescaler[4:0]);
  wire flag_at_16    = prescaler_step && (&prescaler[3:0]);

  // status and mask as seen on the bus
  wire [7:0] status_view = {6'h00, irq_status};
  wire [7:0] mask_view   = {6'h00, irq_mask};

  // two flops before anything reads the pin
  always @(posedge clk) begin
    if (!reset_n) begin
      sub_sync1 <= 1'b0;
      sub_sync2 <= 1'b0;
    end else begin
      sub_sync1 <= sub_clock_pin;
      sub_sync2 <= sub_sync1;
    end
  end

  // previous synchronised level for the rising edge detector
  always @(posedge clk) begin
    if (!reset_n) begin
      sub_prev <= 1'b0;
    end else begin
      sub_prev <= sub_sync2;
    end
  end

  // free-running main clock divider
  always @* begin
    next_main_div = main_div + 1'b1;
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      main_div <= {`WIT_MAIN_DIV_LOG2{1'b0}};
    end else begin
      main_div <= next_main_div;
    end
  end

  // shared prescaler; the counter run bit does not touch it
  always @* begin
    next_prescaler = prescaler;
    if (!prescaler_run) begin
      next_prescaler = {`WIT_PRESCALER_WIDTH{1'b0}};
    end else if (watch_tick) begin
      next_prescaler = prescaler_inc;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      prescaler <= {`WIT_PRESCALER_WIDTH{1'b0}};
    end else begin
      prescaler <= next_prescaler;
    end
  end

  // interval end: prescaler bit (3+sel) falls; prohibited codes never fire
  always @* begin
    interval_end = 1'b0;
    if (prescaler_step) begin
      case (interval_sel)
        3'h0:    interval_end = prescaler_fall[3];
        3'h1:    interval_end = prescaler_fall[4];
        3'h2:    interval_end = prescaler_fall[5];
        3'h3:    interval_end = prescaler_fall[6];
        3'h4:    interval_end = prescaler_fall[7];
        3'h5:    interval_end = prescaler_fall[8];
        default: interval_end = 1'b0;
      endcase
    end
  end

  // watch counter steps at every prescaler wrap, 2^9 watch clocks
  always @* begin
    next_watch_counter = watch_counter;
    if (!watch_counter_run || !prescaler_run) begin
      next_watch_counter = {`WIT_COUNTER_WIDTH{1'b0}};
    end else if (prescaler_wrap) begin
      next_watch_counter = watch_counter + 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      watch_counter <= {`WIT_COUNTER_WIDTH{1'b0}};
    end else begin
      watch_counter <= next_watch_counter;
    end
  end

  // watch flag period select
  always @* begin
    case (flag_period_sel)
      2'b00: begin
        watch_set = flag_at_long;
      end
      2'b01: begin
        watch_set = flag_at_half;
      end
      2'b10: begin
        watch_set = flag_at_32;
      end
      default: begin
        watch_set = flag_at_16;
      end
    endcase
  end

  // clock select is written whole; software stops the timers before a change
  always @* begin
    next_clock_select = clock_select_reg;
    if (write_clock_select) begin
      next_clock_select = reg_wdata;
    end
  end

  // mode register: mask all ones for a byte write, one bit for a bit write
  always @* begin
    next_watch_mode = watch_mode_reg;
    if (write_mode) begin
      next_watch_mode = (watch_mode_reg & ~reg_wmask) | (reg_wdata & reg_wmask);
    end
  end

  always @* begin
    next_irq_mask = irq_mask;
    if (write_mask) begin
      next_irq_mask = reg_wdata[1:0];
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      clock_select_reg <= `WIT_RESET_BYTE;
    end else begin
      clock_select_reg <= next_clock_select;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      watch_mode_reg <= `WIT_RESET_BYTE;
    end else begin
      watch_mode_reg <= next_watch_mode;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      irq_mask <= 2'h0;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // sticky status: an event in the same cycle as a clear wins
  always @* begin
    status_event                    = 2'h0;
    status_event[`WIT_IRQ_WATCH]    = watch_set;
    status_event[`WIT_IRQ_INTERVAL] = interval_end;
  end

  always @* begin
    status_clear = 2'h0;
    if (write_status) begin
      status_clear = reg_wdata[1:0];
    end
  end

  always @* begin
    next_irq_status = status_event | (irq_status & ~status_clear);
  end

  always @* begin
    next_irq = |(next_irq_status & irq_mask);
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // read data stand for one cycle after the strobe, zero otherwise
  always @* begin
    next_rdata = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        `WIT_ADDR_CLOCK_SELECT: begin
          next_rdata = clock_select_reg;
        end
        `WIT_ADDR_MODE: begin
          next_rdata = watch_mode_reg;
        end
        `WIT_ADDR_IRQ_STATUS: begin
          next_rdata = status_view;
        end
        `WIT_ADDR_IRQ_MASK: begin
          next_rdata = mask_view;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // event outputs are one-cycle pulses from flip-flops
  always @(posedge clk) begin
    if (!reset_n) begin
      watch_period_flag <= 1'b0;
    end else begin
      watch_period_flag <= watch_set;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      interval_irq <= 1'b0;
    end else begin
      interval_irq <= interval_end;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      standby_release <= 1'b0;
    end else begin
      standby_release <= watch_set;
    end
  end

endmodule // wit_watch_timer

// ---- hw/wit_consts.vh ----
// register offsets, field positions, reset values and timing constants of the watch timer
`ifndef WIT_CONSTS_VH
`define WIT_CONSTS_VH
`define WIT_ADDR_CLOCK_SELECT  16'hFF42
`define WIT_ADDR_MODE          16'hFF4A
`define WIT_ADDR_IRQ_STATUS    16'hFF4B
`define WIT_ADDR_IRQ_MASK      16'hFF4C
`define WIT_RESET_BYTE         8'h00
`define WIT_BIT_SOURCE_SEL     4
`define WIT_BIT_FLAG_SEL_LOW   0
`define WIT_BIT_PRESCALER_RUN  1
`define WIT_BIT_COUNTER_RUN    2
`define WIT_BIT_FLAG_SEL_HIGH  3
`define WIT_FIELD_INTERVAL_LSB 4
`define WIT_MAIN_DIV_LOG2      8
`define WIT_PRESCALER_WIDTH    9
`define WIT_COUNTER_WIDTH      5
`define WIT_IRQ_WATCH          0
`define WIT_IRQ_INTERVAL       1
`endif

// ---- tb/wit_watch_timer_sva.sv ----
// port assertions for the watch timer
`timescale 1ns/10ps
`include "wit_consts.vh"
module wit_watch_timer_sva (
  input wire        clk, reset_n, reg_write, reg_read, watch_period_flag, interval_irq,
  input wire        standby_release, irq,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata, reg_wmask, reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  a_standby_flag: assert property (standby_release == watch_period_flag)
    else $error("standby release apart from flag");
  a_flag_gap: assert property (watch_period_flag |=> !watch_period_flag [*8])
    else $error("watch flag too soon");
  a_irq_gap: assert property (interval_irq |=> !interval_irq [*8])
    else $error("interval event too soon");
  a_mode_back: assert property ((reg_write && reg_addr == `WIT_ADDR_MODE && reg_wmask == 8'hFF)
    ##1 (reg_read && reg_addr == `WIT_ADDR_MODE) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mode readback");
  a_select_back: assert property ((reg_write && reg_addr == `WIT_ADDR_CLOCK_SELECT)
    ##1 (reg_read && reg_addr == `WIT_ADDR_CLOCK_SELECT) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("clock select readback");
  a_unmapped_zero: assert property (reg_read && reg_addr == 16'h0000 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($rose(reset_n) |-> !irq && !interval_irq && !watch_period_flag)
    else $error("events after reset");
endmodule // wit_watch_timer_sva
bind wit_watch_timer wit_watch_timer_sva u_sva (.*);

// ---- tb/wit_watch_timer_tb.sv ----
// self-checking bench for the watch timer
`timescale 1ns/10ps
`include "wit_consts.vh"
module wit_watch_timer_tb;
  reg         clk = 0, reset_n = 0, sub = 0, wr = 0, rd = 0, s = 0;
  reg  [15:0] addr = 0;
  reg  [7:0]  wd = 0, wm = 0;
  reg  [31:0] lf = 32'hD4E6;
  wire [7:0]  rdata;
  wire        wflag, iirq, irq;
  wire        evs = s ? wflag : iirq;
  integer     n_errors = 0, compares = 0, i, c;
  integer     mdl_sel = 0, mdl_mode = 0;
  wit_watch_timer dut (.clk(clk), .reset_n(reset_n), .sub_clock_pin(sub), .reg_addr(addr),
    .reg_wdata(wd), .reg_wmask(wm), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
    .watch_period_flag(wflag), .interval_irq(iirq), .standby_release(), .irq(irq));
  initial forever #25 clk = ~clk;
  // subsystem clock: one watch tick every 8 cycles
  initial forever #200 sub = ~sub;
  function [31:0] lfsr_next(input [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp); begin
    compares = compares + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
    end
  end endtask
  task close_out; begin
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  // write strobe stays up until the next task lowers it
  task wrt(input [15:0] a, input [7:0] d, input [7:0] m); begin
    addr <= a; wd <= d; wm <= m; wr <= 1;
    if (a == `WIT_ADDR_CLOCK_SELECT) mdl_sel = d;
    if (a == `WIT_ADDR_MODE) mdl_mode = (mdl_mode & ~m) | (d & m);
    @(posedge clk);
  end endtask
  task rdc(input [15:0] a, input [7:0] e); begin
    addr <= a; wr <= 0; rd <= 1;
    @(posedge clk) rd <= 0;
    @(negedge clk) chk(rdata, e);
    if (a == `WIT_ADDR_CLOCK_SELECT) chk(rdata, mdl_sel);
    else if (a == `WIT_ADDR_MODE) chk(rdata, mdl_mode);
    @(posedge clk);
  end endtask
  // cycles between two successive events
  task meas(input integer e); begin
    wr <= 0;
    @(negedge clk);
    for (c = 0; c < 70000 && evs !== 1'b1; c = c + 1) @(negedge clk);
    @(negedge clk);
    // the first period after a mode change may be short
    for (c = 0; c < 70000 && evs !== 1'b1; c = c + 1) @(negedge clk);
    @(negedge clk);
    for (c = 1; c < 70000 && evs !== 1'b1; c = c + 1) @(negedge clk);
    chk(c, e);
    if (c == 70000) close_out;
    else @(posedge clk);
  end endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1;
    rdc(`WIT_ADDR_CLOCK_SELECT, 8'h00);
    rdc(`WIT_ADDR_MODE, 8'h00);
    rdc(16'h0000, 8'h00);
    lf = lfsr_next(lf);
    wrt(`WIT_ADDR_CLOCK_SELECT, lf[7:0] & 8'hEF, 8'hFF);
    rdc(`WIT_ADDR_CLOCK_SELECT, lf[7:0] & 8'hEF);
    wrt(`WIT_ADDR_MODE, 8'hFF, 8'h02);
    rdc(`WIT_ADDR_MODE, 8'h02);
    meas(4096);
    wrt(`WIT_ADDR_MODE, 8'h00, 8'hFF);
    wr <= 0;
    c = 0;
    repeat (5000) @(negedge clk) c = c + iirq;
    chk(c, 0);
    @(posedge clk);
    wrt(`WIT_ADDR_CLOCK_SELECT, 8'h10, 8'hFF);
    wrt(`WIT_ADDR_IRQ_MASK, 8'h02, 8'hFF);
    for (i = 0; i < 6; i = i + 1) begin
      wrt(`WIT_ADDR_MODE, {1'b0, i[2:0], 4'hF}, 8'hFF);
      meas(8 << (4 + i));
    end
    s = 1;
    meas(128);
    wrt(`WIT_ADDR_MODE, 8'h5E, 8'hFF);
    meas(256);
    s = 0;
    wrt(`WIT_ADDR_MODE, 8'h0B, 8'hFF);
    meas(128);
    @(negedge clk) chk(irq, 1);
    @(posedge clk);
    wrt(`WIT_ADDR_MODE, 8'h00, 8'hFF);
    rdc(`WIT_ADDR_MODE, 8'h00);
    wrt(`WIT_ADDR_IRQ_STATUS, 8'h03, 8'hFF);
    rdc(`WIT_ADDR_IRQ_STATUS, 8'h00);
    wrt(`WIT_ADDR_IRQ_MASK, 8'h00, 8'hFF);
    wrt(`WIT_ADDR_MODE, 8'h02, 8'hFF);
    wr <= 0;
    repeat (300) @(posedge clk);
    rdc(`WIT_ADDR_IRQ_STATUS, 8'h02);
    @(negedge clk) chk(irq, 0);
    close_out;
  end
  initial begin
    #4000000;
    n_errors = n_errors + 1;
    close_out;
  end
endmodule // wit_watch_timer_tb
